/* File: wdg_top.sv */
// Watchdog with count source protection and an AXI4-Lite register slave
// Behaviour
// - Protected mode counts low-speed oscillator ticks
// - One decrement per oscillator tick, 4096 period
// - Option one: wait for start register write
// - Option zero: start right after reset
// - Start option is option bit 0, read-only
// - Write 00h then FFh reinitialises counter
// - Protected count ignores wait; stop mode blocked
// - Protected underflow always requests device reset
// - Enabling loads 0FFFh, forces reset action
// - Enabling clears oscillator stop bit
// - Stop-mode bit writes ignored while protected
// - Oscillator stop bit writes ignored while protected
// - Protect option zero sets enable at reset
// - Unprotected underflow: interrupt or reset by bit
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module wdg_top #(
    parameter int PRESC_DIV_P = wdg_pkg::PRESC_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Flash option byte and system status
    input wire logic [7:0] option_byte,
    input wire logic losc_clk_in,
    input wire logic wait_mode,
    // Controls and events toward the system
    output wdg_pkg::wdg_ctl_s ctl,
    output wdg_pkg::wdg_stat_s stat,
    output logic wdt_reset_req,
    output logic irq,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [wdg_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [wdg_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import wdg_pkg::*;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADR_REFRESH) || (a == ADR_START) || (a == ADR_PROT_CTL) ||
                    (a == ADR_CLK_CTL1) || (a == ADR_PMODE1) || (a == ADR_COUNT) ||
                    (a == ADR_IRQ_STAT) || (a == ADR_IRQ_MASK) || (a == ADR_OPTION);
    endfunction : is_mapped

    // Write channel state
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // Read channel state
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;
    // Block state
    logic init_done_ff;
    logic [7:0] opt_ff;
    logic started_ff;
    logic prot_ff;
    logic stop_mode_ff;
    logic losc_stop_ff;
    logic uflow_act_ff;
    logic key_armed_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic losc_prev_ff;
    logic rst_req_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;

    // Write decode: the access happens once both halves are held
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire wr_lane0 = wr_fire & wlane_ff;
    wire wr_refresh = wr_lane0 & (awaddr_ff == ADR_REFRESH);
    wire wr_start = wr_fire & (awaddr_ff == ADR_START);
    wire wr_prot = wr_lane0 & (awaddr_ff == ADR_PROT_CTL);
    wire wr_clk1 = wr_lane0 & (awaddr_ff == ADR_CLK_CTL1);
    wire wr_pm1 = wr_lane0 & (awaddr_ff == ADR_PMODE1);
    wire wr_istat = wr_lane0 & (awaddr_ff == ADR_IRQ_STAT);
    wire wr_imask = wr_lane0 & (awaddr_ff == ADR_IRQ_MASK);

    // protection forced on from option byte
    wire init_prot = ~init_done_ff & ~option_byte[OPT_PROT_BIT];
    // Enable is set by software or by the option byte; clearing is not possible until reset
    wire prot_set = init_prot | (wr_prot & wbyte_ff[PROT_EN_BIT] & ~prot_ff);
    wire prot_now = prot_ff | prot_set;

    // oscillator tick from synchronous oscillator input
    wire losc_tick = losc_clk_in & ~losc_prev_ff;
    wire cpu_tick = (presc_ff == PRESC_W'(PRESC_DIV_P - 1));
    // protected mode uses raw oscillator ticks, no prescaler
    wire cnt_tick = prot_ff ? losc_tick : cpu_tick;
    // wait stalls only the unprotected count
    wire cnt_run = started_ff & (prot_ff | ~wait_mode) & ~ctl.stop_req;
    wire underflow = cnt_run & cnt_tick & (cnt_ff == '0);
    wire key_done = wr_refresh & key_armed_ff & (wbyte_ff == KEY_SECOND);
    wire [CNT_W-1:0] reload_val = prot_now ? RELOAD_PROT : RELOAD_CPU;
    wire uflow_reset = underflow & (prot_ff | uflow_act_ff);
    wire uflow_irq = underflow & ~prot_ff & ~uflow_act_ff;

    wire [IRQ_W-1:0] irq_events = {uflow_reset, uflow_irq};
    wire [IRQ_W-1:0] irq_clr = wr_istat ? wbyte_ff[IRQ_W-1:0] : '0;
    // Set wins over a clear landing in the same cycle
    wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_events;

    // Read decode
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire rd_mapped = is_mapped(s_axi_araddr);
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (s_axi_araddr)
            ADR_PROT_CTL: rd_mux[PROT_EN_BIT] = prot_ff;
            ADR_CLK_CTL1: begin
                rd_mux[CLK_STOP_MODE_BIT] = stop_mode_ff;
                rd_mux[CLK_LOSC_STOP_BIT] = losc_stop_ff;
            end
            ADR_PMODE1: rd_mux[PM_UFLOW_ACT_BIT] = uflow_act_ff;
            ADR_COUNT: rd_mux = {{(DATA_W-CNT_W-1){1'b0}}, started_ff, cnt_ff};
            ADR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
            ADR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
            ADR_OPTION: rd_mux[7:0] = opt_ff;
            default: rd_mux = '0;
        endcase
    end

    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // stop mode never reaches the system while protected
    assign ctl.stop_req = stop_mode_ff & ~prot_ff;
    assign ctl.losc_stop = losc_stop_ff;
    assign ctl.uflow_act = uflow_act_ff;
    assign ctl.prot_active = prot_ff;
    assign stat.running = started_ff;
    assign stat.count = cnt_ff;
    assign wdt_reset_req = rst_req_ff;
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Write address and data, taken in either order
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= '0;
            wlane_ff <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Option byte caught on the first edge after reset release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            init_done_ff <= 1'b0;
            opt_ff <= 8'hff;
        end else if (!init_done_ff) begin
            init_done_ff <= 1'b1;
            opt_ff <= option_byte;
        end
    end

    // Start control
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            started_ff <= 1'b0;
        end else if (!init_done_ff) begin
            // automatic start when option bit is zero
            started_ff <= ~option_byte[OPT_START_BIT];
        end else if (wr_start) begin
            started_ff <= 1'b1;
        end
    end

    // Protection enable and forced clock and mode bits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prot_ff <= 1'b0;
            stop_mode_ff <= RST_STOP_MODE;
            losc_stop_ff <= RST_LOSC_STOP;
            uflow_act_ff <= RST_UFLOW_ACT;
        end else begin
            if (prot_set) begin
                prot_ff <= 1'b1;
            end
            if (wr_clk1 && !prot_now) begin
                stop_mode_ff <= wbyte_ff[CLK_STOP_MODE_BIT];
            end
            if (wr_clk1 && !prot_now) begin
                losc_stop_ff <= wbyte_ff[CLK_LOSC_STOP_BIT];
            end
            if (prot_set) begin
                losc_stop_ff <= 1'b0;
            end
            if (wr_pm1 && !prot_now) begin
                uflow_act_ff <= wbyte_ff[PM_UFLOW_ACT_BIT];
            end
            if (prot_set) begin
                uflow_act_ff <= 1'b1;
            end
        end
    end

    // Refresh key: first byte arms, any other refresh write disarms
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            key_armed_ff <= 1'b0;
        end else if (wr_refresh) begin
            key_armed_ff <= (wbyte_ff == KEY_FIRST);
        end
    end

    // Count source edges and prescaler
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            losc_prev_ff <= 1'b0;
            presc_ff <= '0;
        end else begin
            losc_prev_ff <= losc_clk_in;
            if (cpu_tick || !cnt_run) begin
                presc_ff <= '0;
            end else begin
                presc_ff <= presc_ff + PRESC_W'(1);
            end
        end
    end

    // Down-counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= RELOAD_CPU;
        end else if (!init_done_ff && !option_byte[OPT_PROT_BIT]) begin
            // reset reinitialisation to full protected count
            cnt_ff <= RELOAD_PROT;
        end else if (prot_set || key_done || underflow) begin
            // reload on enable, refresh, or underflow
            cnt_ff <= reload_val;
        end else if (cnt_run && cnt_tick) begin
            cnt_ff <= cnt_ff - CNT_W'(1);
        end
    end

    // Reset request pulse and interrupt registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_req_ff <= 1'b0;
            irq_stat_ff <= '0;
            irq_mask_ff <= RST_IRQ_MASK;
        end else begin
            // underflow while protected or with the reset action selected drives the device reset request
            rst_req_ff <= uflow_reset;
            irq_stat_ff <= nxt_irq_stat;
            if (wr_imask) begin
                irq_mask_ff <= wbyte_ff[IRQ_W-1:0];
            end
        end
    end
endmodule : wdg_top

/* File: wdg_pkg.sv */
// Package for the count-source-protected watchdog: map, fields, reset values
package wdg_pkg;
    // AXI4-Lite geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADR_REFRESH = 18'h00000;
    localparam logic [ADDR_W-1:0] ADR_START = 18'h00004;
    localparam logic [ADDR_W-1:0] ADR_PROT_CTL = 18'h00008;
    localparam logic [ADDR_W-1:0] ADR_CLK_CTL1 = 18'h0000c;
    localparam logic [ADDR_W-1:0] ADR_PMODE1 = 18'h00010;
    localparam logic [ADDR_W-1:0] ADR_COUNT = 18'h00014;
    localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 18'h00018;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 18'h0001c;
    // Option byte index as printed; byte address is four times it
    localparam logic [15:0] IDX_OPTION = 16'hffff;
    localparam logic [ADDR_W-1:0] ADR_OPTION = {IDX_OPTION, 2'b00};
    // Field positions
    localparam int OPT_START_BIT = 0;
    localparam int OPT_PROT_BIT = 7;
    localparam int PROT_EN_BIT = 7;
    localparam int CLK_STOP_MODE_BIT = 0;
    localparam int CLK_LOSC_STOP_BIT = 4;
    localparam int PM_UFLOW_ACT_BIT = 2;
    localparam int IRQ_UFLOW_BIT = 0;
    localparam int IRQ_RST_BIT = 1;
    localparam int IRQ_W = 2;
    // Refresh key sequence
    localparam logic [7:0] KEY_FIRST = 8'h00;
    localparam logic [7:0] KEY_SECOND = 8'hff;
    // Counter geometry and reload values
    localparam int CNT_W = 15;
    localparam logic [CNT_W-1:0] RELOAD_PROT = 15'h0fff;
    localparam logic [CNT_W-1:0] RELOAD_CPU = 15'h7fff;
    localparam int PRESC_DIV = 16;
    localparam int PRESC_W = 7;
    // Reset values
    localparam logic RST_STOP_MODE = 1'b0;
    localparam logic RST_LOSC_STOP = 1'b1;
    localparam logic RST_UFLOW_ACT = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Clock and power-mode controls driven toward the system
    typedef struct packed {
        logic prot_active;
        logic uflow_act;
        logic losc_stop;
        logic stop_req;
    } wdg_ctl_s;

    // Counter status shown to the system
    typedef struct packed {
        logic running;
        logic [CNT_W-1:0] count;
    } wdg_stat_s;
endpackage : wdg_pkg

/* File: wdg_properties.sv */
// Concurrent checks on the watchdog top-level ports
`timescale 1ns/1ps
module wdg_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Observed ports
    input wire logic [7:0] option_byte,
    input wire wdg_pkg::wdg_ctl_s ctl,
    input wire wdg_pkg::wdg_stat_s stat,
    input wire logic wdt_reset_req,
    input wire logic irq
);
    import wdg_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Option byte is captured at the first edge out of reset
    a_start_auto: assert property ($rose(resetn) && !option_byte[0] |=> stat.running)
        else $error("counter idle after auto-start reset");
    a_start_wait: assert property ($rose(resetn) && option_byte[0] |=> !stat.running)
        else $error("counter started without a start write");
    a_prot_option: assert property ($rose(resetn) && !option_byte[7] |=>
        ctl.prot_active && stat.count == 15'h0fff)
        else $error("protection option not applied at reset");
    a_enable_load: assert property ($rose(ctl.prot_active) |-> stat.count == 15'h0fff)
        else $error("enable did not load the start value");
    a_osc_forced: assert property (ctl.prot_active |-> !ctl.losc_stop)
        else $error("oscillator stop bit set while protected");
    a_stop_blocked: assert property (ctl.prot_active |-> !ctl.stop_req)
        else $error("stop request while protected");
    a_act_forced: assert property (ctl.prot_active |-> ctl.uflow_act)
        else $error("underflow action not reset while protected");
    a_count_step: assert property (ctl.prot_active && $past(ctl.prot_active) &&
        stat.count != $past(stat.count) |->
        stat.count == $past(stat.count) - 15'h1 || stat.count == 15'h0fff)
        else $error("protected count moved by other than one");
    a_pulse_reload: assert property (wdt_reset_req && ctl.prot_active |->
        stat.count == 15'h0fff)
        else $error("reset pulse without reload");
    a_pulse_single: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset pulse longer than one cycle");
    a_run_sticky: assert property (stat.running |=> stat.running)
        else $error("counter stopped after start");

    c_prot_on: cover property ($rose(ctl.prot_active));
    c_reset_pulse: cover property (wdt_reset_req);
    c_irq: cover property ($rose(irq));
endmodule : wdg_properties

bind wdg_top wdg_properties wdg_properties_i (.clk_sys(clk_sys), .resetn(resetn),
    .option_byte(option_byte), .ctl(ctl), .stat(stat), .wdt_reset_req(wdt_reset_req),
    .irq(irq));

/* File: watchdog_count_source_protection_tb_top.sv */
// Self-checking bench for the protected watchdog
`timescale 1ns/1ps
module watchdog_count_source_protection_tb_top;
    import wdg_pkg::*;
    logic clk_sys, resetn, losc_clk_in, wait_mode;
    logic [7:0] option_byte;
    wdg_ctl_s ctl;
    wdg_stat_s stat;
    logic wdt_reset_req, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    int n_errors = 0, total_checks = 0, n_pulse = 0, pex = 0, cyc = 0, cnt, n;

    // Short prescaler keeps the unprotected underflow within the run
    wdg_top #(.PRESC_DIV_P(2)) wdg_top_i (.clk_sys(clk_sys), .resetn(resetn),
        .option_byte(option_byte), .losc_clk_in(losc_clk_in), .wait_mode(wait_mode),
        .ctl(ctl), .stat(stat), .wdt_reset_req(wdt_reset_req), .irq(irq),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (wdt_reset_req === 1'b1) n_pulse++;
        if (cyc == 90000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        rd(a);
        chk({r, d}, {RESP_OKAY, x});
    endtask : rc

    // Model: one decrement per tick, underflow reloads and pulses
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            losc_clk_in <= 1'b1;
            @(posedge clk_sys);
            losc_clk_in <= 1'b0;
            if (cnt == 0) begin
                cnt = 'h0fff;
                pex++;
            end else cnt--;
        end
        repeat (3) @(posedge clk_sys);
    endtask : tick

    task automatic rst(input logic [7:0] ob);
        @(posedge clk_sys);
        resetn <= 1'b0;
        option_byte <= ob;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : rst

    initial begin
        {resetn, losc_clk_in, wait_mode, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        option_byte = 8'hff;
        void'($urandom(73));
        rst(8'hff);
        rc(ADR_OPTION, 32'hff);
        wr(ADR_OPTION, 32'h0);
        rc(ADR_OPTION, 32'hff);
        tick(5);
        rc(ADR_COUNT, 32'h7fff);
        wr(ADR_CLK_CTL1, 32'h10);
        wr(ADR_START, $urandom);
        wr(ADR_PROT_CTL, 32'h80);
        cnt = 'h0fff;
        rc(ADR_COUNT, 32'h8fff);
        chk(ctl, 4'b1100);
        wr(ADR_CLK_CTL1, 32'h11);
        wr(ADR_PMODE1, 32'h0);
        rc(ADR_CLK_CTL1, 32'h0);
        rc(ADR_PMODE1, 32'h4);
        chk(ctl, 4'b1100);
        $display("test protect_enable done");
        // Wait mode must not stall the protected count
        wait_mode <= 1'b1;
        n = $urandom_range(200, 1);
        tick(n);
        rc(ADR_COUNT, 32'h8000 | cnt);
        wr(ADR_REFRESH, 32'h0);
        wr(ADR_REFRESH, 32'hff);
        cnt = 'h0fff;
        rc(ADR_COUNT, 32'h8fff);
        tick(3);
        wr(ADR_REFRESH, 32'h0);
        wr(ADR_REFRESH, 32'h55);
        wr(ADR_REFRESH, 32'hff);
        rc(ADR_COUNT, 32'h8000 | cnt);
        $display("test refresh done");
        n_pulse = 0;
        pex = 0;
        tick(cnt);
        rc(ADR_COUNT, 32'h8000);
        chk(n_pulse, pex);
        tick(1);
        rc(ADR_COUNT, 32'h8000 | cnt);
        chk(n_pulse, pex);
        $display("test underflow done");
        rst(8'h7e);
        chk(ctl, 4'b1100);
        cnt = 'h0fff;
        tick(2);
        rc(ADR_COUNT, 32'h8000 | cnt);
        rd(18'h00100);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        $display("test protect_at_reset done");
        rst(8'hfe);
        wait_mode <= 1'b0;
        wr(ADR_IRQ_MASK, 32'h1);
        while (irq !== 1'b1) @(posedge clk_sys);
        rc(ADR_IRQ_STAT, 32'h1);
        chk(n_pulse, pex);
        wr(ADR_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        wr(ADR_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        wr(ADR_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        rc(ADR_IRQ_STAT, 32'h0);
        $display("test interrupt done");
        // Unprotected controls take writes, then freeze once enabled
        wr(ADR_PMODE1, 32'h4);
        chk(r, RESP_OKAY);
        wr(ADR_CLK_CTL1, 32'h1);
        chk(ctl, 4'b0101);
        rd(ADR_COUNT);
        n = d;
        repeat (8) @(posedge clk_sys);
        rc(ADR_COUNT, n);
        wr(ADR_PROT_CTL, 32'h80);
        chk(ctl, 4'b1100);
        rc(ADR_CLK_CTL1, 32'h1);
        rc(ADR_COUNT, 32'h8fff);
        wr(18'h00100, 32'h0);
        chk(r, RESP_SLVERR);
        $display("test unprotected_controls done");
        test_done();
    end
endmodule : watchdog_count_source_protection_tb_top
